// file: rtl/ftd_field_threshold_trim_diag.sv
// Field thresholds, bias trim settings, field flags and their serial register port.
//
// Contract
// - Hold an 8-bit bias trim value, 0 to 255, reducing selected axis bias.
// - Trim value zero applies no bias reduction at all.
// - X and Y enable bits each select whether their axis receives the trim.
// - With both enables set, both axes get the same reduction.
// - Low flag sets below low threshold, high flag above high threshold.
// - Thresholds live in register 6: low in bits 7-5, high in 4-2.
// - Codes 0-7 rise at 26..126 mT; falling points sit 6 mT lower.
// - Low code may exceed high code; comparisons stay independent.
// - Status register 27 shows high flag in bit 7, low flag in bit 6.
// - Live flag states also drive two dedicated output pins.
// - A register 27 read is answered in the next frame, not the same one.
// - Healthy front end with field in range reads 0x0f in register 27.
`timescale 1ns/1ps
`default_nettype none
module ftd_field_threshold_trim_diag
  import ftd_pkg::*;
(
  input  wire logic       CLK_SYS,
  input  wire logic       RST,
  input  wire logic       CE,
  input  wire logic       SPI_SCK,
  input  wire logic       SPI_CS_N,
  input  wire logic       SPI_MOSI,
  output var  logic       SPI_MISO_O,
  output var  logic       SPI_MISO_OE,
  input  wire logic [7:0] FIELD_MT,
  input  wire logic       FRONT_END_OK,
  output var  logic [7:0] BIAS_TRIM_X,
  output var  logic [7:0] BIAS_TRIM_Y,
  output var  logic       FIELD_LOW_FLAG,
  output var  logic       FIELD_HIGH_FLAG
);
  import ftd_pkg::*;

  // Serial pins come from the host's clock world and are resynchronised.
  logic sck_meta;
  logic sck_sync;
  logic sck_dly;
  logic cs_n_meta;
  logic cs_n_sync;
  logic cs_n_dly;
  logic mosi_meta;
  logic mosi_sync;

  logic sck_rise;
  logic sck_fall;
  logic cs_start;
  logic cs_end;

  ftd_spi_e   spi_state;
  logic [4:0]  bit_cnt;
  logic [15:0] rx_shift;
  logic [15:0] next_rx;
  logic [15:0] tx_shift;
  logic        frame_done;
  logic [15:0] frame_word;

  logic        pend_valid;
  logic [4:0]  pend_addr;
  logic [7:0]  rd_value;

  logic [7:0]  bias_trim_value;
  logic        trim_enable_x_axis;
  logic        trim_enable_y_axis;
  logic [7:0]  thresh_reg;
  logic [2:0]  field_low_threshold;
  logic [2:0]  field_high_threshold;
  logic        field_low_flag;
  logic        field_high_flag;
  logic [7:0]  field_flag_status;

  logic [2:0]  frm_cmd;
  logic [4:0]  frm_addr;
  logic [7:0]  frm_data;

  // Two flip-flops per pin, plus a third on clock and select for edge detection; only the second stage and later are used.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      sck_meta  <= 1'b0;
      sck_sync  <= 1'b0;
      sck_dly   <= 1'b0;
      cs_n_meta <= 1'b1;
      cs_n_sync <= 1'b1;
      cs_n_dly  <= 1'b1;
      mosi_meta <= 1'b0;
      mosi_sync <= 1'b0;
    end else if (CE) begin
      sck_meta  <= SPI_SCK;
      sck_sync  <= sck_meta;
      sck_dly   <= sck_sync;
      cs_n_meta <= SPI_CS_N;
      cs_n_sync <= cs_n_meta;
      cs_n_dly  <= cs_n_sync;
      mosi_meta <= SPI_MOSI;
      mosi_sync <= mosi_meta;
    end
  end

  // Edge events on the resynchronised serial clock and select.
  assign sck_rise = CE && !cs_n_sync && sck_sync && !sck_dly;
  assign sck_fall = CE && !cs_n_sync && !sck_sync && sck_dly;
  assign cs_start = CE && !cs_n_sync && cs_n_dly;
  assign cs_end   = CE && cs_n_sync && !cs_n_dly;
  assign next_rx  = {rx_shift[14:0], mosi_sync};

  // Frame state: a frame runs from select low to select high.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      spi_state <= FTD_IDLE;
    end else if (CE) begin
      case (spi_state)
        FTD_IDLE: begin
          if (cs_start) begin
            spi_state <= FTD_FRAME;
          end
        end
        FTD_FRAME: begin
          if (cs_end) begin
            spi_state <= FTD_IDLE;
          end
        end
        default: spi_state <= FTD_IDLE;
      endcase
    end
  end

  // Receive shifter; a frame counts only once all sixteen bits arrived.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      bit_cnt    <= 5'h00;
      rx_shift   <= 16'h0000;
      frame_done <= 1'b0;
      frame_word <= 16'h0000;
    end else if (CE) begin
      frame_done <= 1'b0;
      if (cs_start) begin
        bit_cnt <= 5'h00;
      end else if (sck_rise && spi_state == FTD_FRAME) begin
        rx_shift <= next_rx;
        bit_cnt  <= (bit_cnt == FRAME_LAST + 5'h01) ? bit_cnt : bit_cnt + 5'h01;
        if (bit_cnt == FRAME_LAST) begin
          frame_done <= 1'b1;
          frame_word <= next_rx;
        end
      end
    end
  end

  assign frm_cmd  = frame_word[CMD_MSB:CMD_LSB];
  assign frm_addr = frame_word[ADDR_MSB:ADDR_LSB];
  assign frm_data = frame_word[DATA_MSB:0];

  // Remember what the next frame must answer; the reply is deferred by design.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      pend_valid <= 1'b0;
      pend_addr  <= 5'h00;
    end else if (CE) begin
      if (frame_done) begin
        pend_valid <= (frm_cmd == CMD_READ) || (frm_cmd == CMD_WRITE);
        pend_addr  <= frm_addr;
      end else if (cs_start) begin
        pend_valid <= 1'b0;
      end
    end
  end

  // Register read multiplexer; unmapped addresses read as zero.
  always_comb begin
    case (pend_addr)
      REG_BIAS_TRIM: rd_value = bias_trim_value;
      REG_TRIM_EN:   rd_value = {6'h00, trim_enable_y_axis, trim_enable_x_axis};
      REG_THRESH:    rd_value = thresh_reg;
      REG_STATUS:    rd_value = field_flag_status;
      default:       rd_value = 8'h00;
    endcase
  end

  // Transmit shifter loads at frame start, value first, then eight zeros.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      tx_shift    <= 16'h0000;
      SPI_MISO_O  <= 1'b0;
      SPI_MISO_OE <= 1'b0;
    end else if (CE) begin
      SPI_MISO_OE <= !cs_n_sync;
      if (cs_start) begin
        tx_shift   <= pend_valid ? {rd_value, 8'h00} : 16'h0000;
        SPI_MISO_O <= pend_valid ? rd_value[7] : 1'b0;
      end else if (sck_fall) begin
        tx_shift   <= {tx_shift[14:0], 1'b0};
        SPI_MISO_O <= tx_shift[14];
      end
    end
  end

  // Writable settings; status is read-only and writes to it are dropped.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      bias_trim_value    <= RST_BIAS_TRIM;
      trim_enable_x_axis <= RST_TRIM_EN[EN_X_BIT];
      trim_enable_y_axis <= RST_TRIM_EN[EN_Y_BIT];
      thresh_reg         <= RST_THRESH;
    end else if (CE && frame_done && frm_cmd == CMD_WRITE) begin
      case (frm_addr)
        REG_BIAS_TRIM: bias_trim_value <= frm_data;
        REG_TRIM_EN: begin
          trim_enable_x_axis <= frm_data[EN_X_BIT];
          trim_enable_y_axis <= frm_data[EN_Y_BIT];
        end
        REG_THRESH: thresh_reg <= {frm_data[7:2], 2'b00};
        default: thresh_reg <= thresh_reg;
      endcase
    end
  end

  assign field_low_threshold  = thresh_reg[LOW_THR_MSB:LOW_THR_LSB];
  assign field_high_threshold = thresh_reg[HIGH_THR_MSB:HIGH_THR_LSB];

  // Per-axis bias reduction; equal on both axes when both enables are set.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      BIAS_TRIM_X <= 8'h00;
      BIAS_TRIM_Y <= 8'h00;
    end else if (CE) begin
      BIAS_TRIM_X <= trim_enable_x_axis ? bias_trim_value : 8'h00;
      BIAS_TRIM_Y <= trim_enable_y_axis ? bias_trim_value : 8'h00;
    end
  end

  // The two comparisons are independent, so crossed thresholds are legal.
  ftd_flag_hyst u_low_flag (
    .clk     (CLK_SYS),
    .rst     (RST),
    .ce      (CE),
    .is_high (1'b0),
    .code    (field_low_threshold),
    .field   (FIELD_MT),
    .flag    (field_low_flag)
  );

  ftd_flag_hyst u_high_flag (
    .clk     (CLK_SYS),
    .rst     (RST),
    .ce      (CE),
    .is_high (1'b1),
    .code    (field_high_threshold),
    .field   (FIELD_MT),
    .flag    (field_high_flag)
  );

  // Lower bits give the integrity pattern only while the front end is healthy.
  always_comb begin
    field_flag_status = 8'h00;
    field_flag_status[STAT_HIGH_BIT] = field_high_flag;
    field_flag_status[STAT_LOW_BIT]  = field_low_flag;
    field_flag_status[5:0] = FRONT_END_OK ? HEALTHY_PATTERN : 6'h00;
  end

  // Flag pins mirror the live flag flip-flops.
  assign FIELD_LOW_FLAG  = field_low_flag;
  assign FIELD_HIGH_FLAG = field_high_flag;

  // Assertions.
  sequence s_status_read;
    frame_done && frm_cmd == CMD_READ && frm_addr == REG_STATUS;
  endsequence

  sequence s_next_load;
    cs_start && pend_valid && pend_addr == REG_STATUS;
  endsequence

  a_trim_zero_off: assert property (@(posedge CLK_SYS) disable iff (RST)
    CE && bias_trim_value == 8'h00 |=> BIAS_TRIM_X == 8'h00 && BIAS_TRIM_Y == 8'h00)
    else $error("Zero trim value still reduced an axis bias.");

  a_trim_axis_select: assert property (@(posedge CLK_SYS) disable iff (RST)
    CE && trim_enable_x_axis && !trim_enable_y_axis
    |=> BIAS_TRIM_X == $past(bias_trim_value) && BIAS_TRIM_Y == 8'h00)
    else $error("X-only trim enable did not steer the trim to X alone.");

  a_trim_both_equal: assert property (@(posedge CLK_SYS) disable iff (RST)
    CE && trim_enable_x_axis && trim_enable_y_axis |=> BIAS_TRIM_X == BIAS_TRIM_Y)
    else $error("Both axes enabled but trims differ.");

  a_thresh_write: assert property (@(posedge CLK_SYS) disable iff (RST)
    CE && frame_done && frm_cmd == CMD_WRITE && frm_addr == REG_THRESH
    |=> field_low_threshold == $past(frm_data[7:5])
        && field_high_threshold == $past(frm_data[4:2]))
    else $error("Threshold write not reflected in the threshold fields.");

  a_bias_write: assert property (@(posedge CLK_SYS) disable iff (RST)
    CE && frame_done && frm_cmd == CMD_WRITE && frm_addr == REG_BIAS_TRIM
    |=> bias_trim_value == $past(frm_data))
    else $error("Trim value write did not take effect.");

  a_status_flags: assert property (@(posedge CLK_SYS) disable iff (RST)
    field_flag_status[STAT_HIGH_BIT] == FIELD_HIGH_FLAG
    && field_flag_status[STAT_LOW_BIT] == FIELD_LOW_FLAG)
    else $error("Status flag bits disagree with the flag pins.");

  a_status_healthy: assert property (@(posedge CLK_SYS) disable iff (RST)
    FRONT_END_OK && !field_low_flag && !field_high_flag |-> field_flag_status == 8'h0f)
    else $error("Healthy in-range status did not read 0x0f.");

  a_read_deferred: assert property (@(posedge CLK_SYS) disable iff (RST)
    s_status_read |=> pend_valid && pend_addr == REG_STATUS)
    else $error("Status read request was not queued for the next frame.");

  a_read_answer: assert property (@(posedge CLK_SYS) disable iff (RST)
    s_next_load |=> tx_shift[15:8] == $past(field_flag_status)
                    && SPI_MISO_O == $past(field_flag_status[7]))
    else $error("Next frame did not carry the status value.");
endmodule
`default_nettype wire

// file: rtl/ftd_pkg.sv
// Shared constants, types and lookups for the field threshold, trim and flag block.
package ftd_pkg;
  // Register addresses carried in the 5-bit address field of a frame.
  localparam logic [4:0] REG_BIAS_TRIM = 5'h02;
  localparam logic [4:0] REG_TRIM_EN   = 5'h03;
  localparam logic [4:0] REG_THRESH    = 5'h06;
  localparam logic [4:0] REG_STATUS    = 5'h1b;
  // Frame commands in the top three bits of a frame.
  localparam logic [2:0] CMD_READ  = 3'h2;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  // Frame layout, most significant bit first.
  localparam logic [4:0] FRAME_LAST = 5'h0f;
  localparam int CMD_MSB  = 15;
  localparam int CMD_LSB  = 13;
  localparam int ADDR_MSB = 12;
  localparam int ADDR_LSB = 8;
  localparam int DATA_MSB = 7;
  // Field positions inside the registers.
  localparam int LOW_THR_MSB  = 7;
  localparam int LOW_THR_LSB  = 5;
  localparam int HIGH_THR_MSB = 4;
  localparam int HIGH_THR_LSB = 2;
  localparam int EN_X_BIT     = 0;
  localparam int EN_Y_BIT     = 1;
  localparam int STAT_HIGH_BIT = 7;
  localparam int STAT_LOW_BIT  = 6;
  // Reset values.
  localparam logic [7:0] RST_BIAS_TRIM = 8'h00;
  localparam logic [1:0] RST_TRIM_EN   = 2'h0;
  localparam logic [7:0] RST_THRESH    = 8'h1c;
  // Lower status bits while the front end reports healthy.
  localparam logic [5:0] HEALTHY_PATTERN = 6'h0f;
  // Hysteresis between rising and falling trip points, in mT.
  localparam logic [7:0] HYST_MT = 8'h06;

  typedef enum {FTD_IDLE, FTD_FRAME} ftd_spi_e;

  // Rising-field trip point in mT for a 3-bit threshold code.
  function automatic logic [7:0] ftd_trip_rise(input logic [2:0] code);
    case (code)
      3'h0: ftd_trip_rise = 8'h1a;
      3'h1: ftd_trip_rise = 8'h29;
      3'h2: ftd_trip_rise = 8'h38;
      3'h3: ftd_trip_rise = 8'h46;
      3'h4: ftd_trip_rise = 8'h54;
      3'h5: ftd_trip_rise = 8'h62;
      3'h6: ftd_trip_rise = 8'h70;
      default: ftd_trip_rise = 8'h7e;
    endcase
  endfunction

  // Falling-field trip point sits one hysteresis step below the rising one.
  function automatic logic [7:0] ftd_trip_fall(input logic [2:0] code);
    ftd_trip_fall = ftd_trip_rise(code) - HYST_MT;
  endfunction
endpackage

// file: rtl/ftd_flag_hyst.sv
// One out-of-range field flag with a hysteresis band between two trip points.
`timescale 1ns/1ps
`default_nettype none
module ftd_flag_hyst
  import ftd_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       is_high,
  input  wire logic [2:0] code,
  input  wire logic [7:0] field,
  output var  logic       flag
);
  logic [7:0] rise;
  logic [7:0] fall;

  // Trip points follow the live code, so a new threshold acts at once.
  assign rise = ftd_trip_rise(code);
  assign fall = ftd_trip_fall(code);

  // A high flag sets above the rising point and a low flag below the falling
  // point; inside the band the flag keeps its state to avoid chatter.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag <= 1'b0;
    end else if (ce) begin
      if (is_high) begin
        if (field > rise) begin
          flag <= 1'b1;
        end else if (field < fall) begin
          flag <= 1'b0;
        end
      end else begin
        if (field < fall) begin
          flag <= 1'b1;
        end else if (field > rise) begin
          flag <= 1'b0;
        end
      end
    end
  end

  a_band_holds_flag: assert property (@(posedge clk) disable iff (rst)
    ce && field >= fall && field <= rise |=> $stable(flag))
    else $error("Flag changed while the field sat inside the band.");

  a_trip_sets_flag: assert property (@(posedge clk) disable iff (rst)
    ce && (is_high ? field > rise : field < fall) |=> flag)
    else $error("Flag not set after the field crossed its trip point.");
endmodule
`default_nettype wire

// file: verif/ftd_spi_host.sv
// Serial host model that sends 16-bit register frames to the block.
`timescale 1ns/1ps
`default_nettype none
module ftd_spi_host (
  input  wire logic clk,
  input  wire logic miso_o,
  input  wire logic miso_oe,
  output var  logic sck,
  output var  logic cs_n,
  output var  logic mosi
);
  logic miso_last;
  logic miso;

  // Idle levels: select high, clock low between frames.
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
    miso_last = 1'b0;
  end

  // A released data line shows the inverse of its last value, so stale data never matches.
  always @(posedge clk) begin
    if (miso_oe) begin
      miso_last <= miso_o;
    end
  end
  assign miso = miso_oe ? miso_o : ~miso_last;

  // Mode 0 frame, command bits first; five-cycle phases keep above the four-cycle minimum.
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    @(posedge clk) #1 cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      mosi = tx[i];
      repeat (5) @(posedge clk);
      #1 sck = 1'b1;
      rx[i] = miso;
      repeat (5) @(posedge clk);
      #1 sck = 1'b0;
    end
    repeat (5) @(posedge clk);
    #1 cs_n = 1'b1;
    mosi = ~mosi;
    repeat (5) @(posedge clk);
    #1;
  endtask
endmodule
`default_nettype wire

// file: verif/ftd_field_threshold_trim_diag_test.sv
// Self-checking bench: register frames, field sweeps and trim outputs against a model.
`timescale 1ns/1ps
`default_nettype none
module ftd_field_threshold_trim_diag_test;
  import ftd_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic        fe = 1'b1;
  logic [7:0]  field = 8'h3c;
  logic        sck, cs_n, mosi, miso_o, miso_oe, low_f, high_f;
  logic [7:0]  trim_x, trim_y;
  int          rise [8] = '{26, 41, 56, 70, 84, 98, 112, 126};
  int          offs [7] = '{1, 0, -6, -7, -6, 0, 1};
  logic [7:0]  m_trim = 8'h00;
  logic [1:0]  m_en = 2'h0;
  logic [7:0]  m_thr = 8'h1c;
  logic        m_hi = 1'b0;
  logic        m_lo = 1'b0;
  logic [15:0] pend = 16'h0000;
  logic        pend_ok = 1'b1;
  logic [31:0] lfsr = 32'he9e1;
  int          err_total = 0;
  int          comparisons = 0;
  int          cyc = 0;

  // Free-running 125 MHz clock.
  always #4 clk = ~clk;

  ftd_field_threshold_trim_diag uut (
    .CLK_SYS(clk), .RST(rst), .CE(ce), .SPI_SCK(sck), .SPI_CS_N(cs_n), .SPI_MOSI(mosi),
    .SPI_MISO_O(miso_o), .SPI_MISO_OE(miso_oe), .FIELD_MT(field), .FRONT_END_OK(fe),
    .BIAS_TRIM_X(trim_x), .BIAS_TRIM_Y(trim_y), .FIELD_LOW_FLAG(low_f),
    .FIELD_HIGH_FLAG(high_f)
  );

  ftd_spi_host host (
    .clk(clk), .miso_o(miso_o), .miso_oe(miso_oe), .sck(sck), .cs_n(cs_n), .mosi(mosi)
  );

  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk_reg(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_pin(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  // One frame; its reply is checked against what the previous frame asked for.
  task automatic frame(input logic [2:0] c, input logic [4:0] a, input logic [7:0] d);
    logic [15:0] rx;
    logic [7:0]  v;
    host.xfer({c, a, d}, rx);
    if (pend_ok) chk_reg("reply", pend, rx);
    pend_ok = 1'b1;
    if (c == 3'b100) begin
      case (a)
        5'h02: m_trim = d;
        5'h03: m_en = d[1:0];
        5'h06: m_thr = {d[7:2], 2'b00};
      endcase
    end
    case (a)
      5'h02: v = m_trim;
      5'h03: v = {6'h00, m_en};
      5'h06: v = m_thr;
      5'h1b: v = {m_hi, m_lo, fe ? 6'h0f : 6'h00};
      default: v = 8'h00;
    endcase
    pend = {v, 8'h00};
  endtask

  // Applies a field, lets the flags settle, then compares flags and trim pins.
  task automatic fld(input int f);
    logic [2:0] h;
    logic [2:0] l;
    h = m_thr[4:2];
    l = m_thr[7:5];
    @(posedge clk) #1 field = f[7:0];
    repeat (3) @(posedge clk);
    #1;
    if (f > rise[h]) m_hi = 1'b1;
    else if (f < rise[h] - 6) m_hi = 1'b0;
    if (f < rise[l] - 6) m_lo = 1'b1;
    else if (f > rise[l]) m_lo = 1'b0;
    chk_pin("high flag", {7'h00, m_hi}, {7'h00, high_f});
    chk_pin("low flag", {7'h00, m_lo}, {7'h00, low_f});
    chk_pin("trim x", m_en[0] ? m_trim : 8'h00, trim_x);
    chk_pin("trim y", m_en[1] ? m_trim : 8'h00, trim_y);
  endtask

  // Hang guard; the whole run needs roughly ten thousand cycles.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      conclude();
    end
  end

  // Main sequence.
  initial begin
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    fld(60);
    frame(3'b010, 5'h06, 8'h00);
    frame(3'b010, 5'h02, 8'h00);
    frame(3'b010, 5'h03, 8'h00);
    frame(3'b010, 5'h1b, 8'h00);
    frame(3'b010, 5'h06, 8'h00);
    for (int t = 0; t < 3; t++) begin
      lfsr = next_rand(lfsr);
      frame(3'b100, 5'h02, t == 0 ? 8'h00 : t == 1 ? 8'hff : lfsr[7:0]);
      for (int e = 0; e < 4; e++) begin
        frame(3'b100, 5'h03, 8'(e));
        fld(60);
      end
    end
    // Every code on both thresholds, walked up and down through each hysteresis band.
    for (int c = 0; c < 8; c++) begin
      fe = (c % 3) != 0;
      frame(3'b100, 5'h06, {3'(7 - c), 3'(c), 2'b11});
      for (int k = 0; k < 14; k++) begin
        fld(rise[k < 7 ? c : 7 - c] + offs[k % 7]);
      end
      lfsr = next_rand(lfsr);
      fld(int'(lfsr[7:0]));
      frame(3'b010, 5'h1b, 8'h00);
      frame(3'b010, 5'h06, 8'h00);
    end
    // Refused writes and an unmapped read leave the registers untouched.
    frame(3'b100, 5'h1b, 8'hff);
    frame(3'b100, 5'h1f, 8'hff);
    frame(3'b010, 5'h1f, 8'h00);
    frame(3'b010, 5'h1b, 8'h00);
    frame(3'b010, 5'h06, 8'h00);
    frame(3'b010, 5'h06, 8'h00);
    // With the clock enable low the high flag must not follow a large field step.
    @(posedge clk) #1 ce = 1'b0;
    field = 8'hc8;
    repeat (4) @(posedge clk);
    #1 chk_pin("held flag", {7'h00, m_hi}, {7'h00, high_f});
    ce = 1'b1;
    fld(200);
    conclude();
  end
endmodule
`default_nettype wire
